/* design/mir_pkg.sv */
// Function
// RULE_01: Enabled new value drives interrupt low, held
// RULE_02: Status bits: freq, peak, coarse, fine
// RULE_03: Enable bit gates its event onto interrupt
// RULE_04: Status sets regardless of enable bits
// RULE_05: Completed status read releases interrupt high
// RULE_06: Host rechecks interrupt, rereads if still low
// RULE_07: Status read-only, enable read/write, two nibbles
// RULE_08: Counters at 0A/0B: 24 bits, 6 reads
// RULE_09: Peaks at 0C/0D: 16 bits, 4 reads
// RULE_10: Coarse 0E 16b/4 reads, fine 0F 24b/6
// RULE_11: Measurement registers ignore writes
// RULE_12: Clear strobe falling edge clears status bit
// RULE_13: Exact read counts; address strobe resets counter
// RULE_14: First ADC read strobe exceeds sample period
// RULE_15: Timebase read keeps frequency status bit
// RULE_16: Either peak read clears peak status bit
// RULE_17: Two nibbles, MSB first, address strobe restarts
// RULE_18: Reset clears enable bits to zero
// RULE_19: Shared register; interrupt is NOR of masked status
// RULE_20: First nibble read captures value into holding
package mir_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_INTR = 4'h9;
    localparam logic [3:0] ADDR_TIMEBASE = 4'hA;
    localparam logic [3:0] ADDR_SIGNAL = 4'hB;
    localparam logic [3:0] ADDR_POS_PEAK = 4'hC;
    localparam logic [3:0] ADDR_NEG_PEAK = 4'hD;
    localparam logic [3:0] ADDR_COARSE = 4'hE;
    localparam logic [3:0] ADDR_FINE = 4'hF;
    localparam int STATUS_POS = 4;
    localparam int ENABLE_POS = 0;
    localparam int BIT_FREQ = 3;
    localparam int BIT_PEAK = 2;
    localparam int BIT_COARSE = 1;
    localparam int BIT_FINE = 0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic [2:0] NIB_WIDE = 3'h6;
    localparam logic [2:0] NIB_HALF = 3'h4;
    localparam logic [2:0] NIB_BYTE = 3'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int STROBE_MIN_NS = 2000;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_PERIOD_NS = 12000;
    localparam int SAMPLE_PERIOD_CYC = (SAMPLE_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int PHASE_CYC = 8;

    // Nibble count of a read sequence at an address
    function automatic logic [2:0] mirNibbleCount(input logic [3:0] addr);
        case (addr)
            ADDR_TIMEBASE, ADDR_SIGNAL, ADDR_FINE: return NIB_WIDE;
            ADDR_POS_PEAK, ADDR_NEG_PEAK, ADDR_COARSE: return NIB_HALF;
            default: return NIB_BYTE;
        endcase
    endfunction

endpackage

/* design/mir_bus_if.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Multiplexed nibble bus between host and meter
// ----------------------------------------------------------------
interface mir_bus_if;
    logic csN;
    logic ale;
    logic rdN;
    logic wrN;
    logic [3:0] hostAd;
    logic hostAdDriveN;
    logic [3:0] devAd;
    logic devAdDriveN;
    logic irqOutN;
    logic [3:0] ad;

    // Wire level; pull-up when nobody drives
    assign ad = !devAdDriveN ? devAd : (!hostAdDriveN ? hostAd : 4'hF);

    modport device (
        input csN, ale, rdN, wrN, ad,
        output devAd, devAdDriveN, irqOutN
    );
    modport host (
        output csN, ale, rdN, wrN, hostAd, hostAdDriveN,
        input ad, irqOutN
    );
endinterface

/* design/mir_device.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Meter end: interrupt status/enable and measurement readout
// ----------------------------------------------------------------
module mir_device
    import mir_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [23:0] timebaseCount,
    input wire logic [23:0] signalCount,
    input wire logic freqValid,
    input wire logic [15:0] positivePeak,
    input wire logic [15:0] negativePeak,
    input wire logic peakValid,
    input wire logic [15:0] coarseAdcResult,
    input wire logic coarseValid,
    input wire logic [23:0] fineAdcResult,
    input wire logic fineValid,
    output logic [3:0] eventStatus,
    output logic [3:0] eventEnable,
    mir_bus_if.device bus
);

    typedef struct packed {
        logic [1:0] csS;
        logic [1:0] aleS;
        logic [1:0] rdS;
        logic [1:0] wrS;
        logic [7:0] adS;
        logic rdPrev;
        logic wrPrev;
        logic [3:0] addr;
        logic [2:0] nibbleCycleCounter;
        logic [23:0] hold;
        logic [3:0] status;
        logic [3:0] enable;
        logic [3:0] acked;
        logic [3:0] statusClearStrobe;
        logic [3:0] strobePrev;
        logic [3:0] adOut;
        logic adDriveN;
        logic irqOutN;
    } mir_dev_state_t;

    mir_dev_state_t s;
    mir_dev_state_t next_s;

    // Fresh value of the addressed register
    function automatic logic [23:0] readValue(input logic [3:0] addr,
                                              input logic [3:0] st,
                                              input logic [3:0] en);
        logic [23:0] v;
        v = 24'h000000;
        case (addr)
            ADDR_INTR: v = {16'h0000, st, en};
            ADDR_TIMEBASE: v = timebaseCount;
            ADDR_SIGNAL: v = signalCount;
            ADDR_POS_PEAK: v = {8'h00, positivePeak};
            ADDR_NEG_PEAK: v = {8'h00, negativePeak};
            ADDR_COARSE: v = {8'h00, coarseAdcResult};
            ADDR_FINE: v = fineAdcResult;
            default: v = 24'h000000;
        endcase
        return v;
    endfunction

    // Nibble idx of a total-nibble value, most significant first
    function automatic logic [3:0] nibbleSel(input logic [23:0] v,
                                             input logic [2:0] total,
                                             input logic [2:0] idx);
        logic [2:0] pos;
        pos = total - idx - 3'h1;
        return v[{pos, 2'b00} +: 4];
    endfunction

    logic sel;
    logic aleHi;
    logic rdFall;
    logic rdRise;
    logic wrRise;
    logic [2:0] total;
    logic [2:0] countInc;
    logic [23:0] captured;
    logic [3:0] done;
    logic [3:0] ackSet;
    logic [3:0] clearFall;
    logic [3:0] newVals;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        done = 4'h0;
        ackSet = 4'h0;
        captured = s.hold;
        // Pins pass two flops before use
        next_s.csS = {s.csS[0], bus.csN};
        next_s.aleS = {s.aleS[0], bus.ale};
        next_s.rdS = {s.rdS[0], bus.rdN};
        next_s.wrS = {s.wrS[0], bus.wrN};
        next_s.adS = {s.adS[3:0], bus.ad};
        sel = ~s.csS[1];
        aleHi = s.aleS[1] & sel;
        rdFall = sel & s.rdPrev & ~s.rdS[1] & ~aleHi;
        rdRise = ~s.rdPrev & s.rdS[1] & ~s.adDriveN;
        wrRise = sel & ~s.wrPrev & s.wrS[1] & ~aleHi;
        next_s.rdPrev = s.rdS[1];
        next_s.wrPrev = s.wrS[1];
        total = mirNibbleCount(s.addr);
        countInc = s.nibbleCycleCounter + 3'h1;
        newVals = {freqValid, peakValid, coarseValid, fineValid}; // RULE_02

        // Address phase restarts any sequence
        if (aleHi)
        begin
            next_s.addr = s.adS[7:4];
            next_s.nibbleCycleCounter = 3'h0; // RULE_13 RULE_17
            next_s.adDriveN = 1'b1;
        end

        // Read strobe low: drive the next nibble
        if (rdFall)
        begin
            if (s.nibbleCycleCounter == 3'h0)
            begin
                captured = readValue(s.addr, s.status, s.enable); // RULE_20
                next_s.hold = captured;
            end
            next_s.adOut = nibbleSel(captured, total, s.nibbleCycleCounter); // RULE_17
            next_s.adDriveN = 1'b0;
        end

        // Read strobe high: advance; last nibble ends the sequence
        if (rdRise)
        begin
            next_s.adDriveN = 1'b1;
            next_s.nibbleCycleCounter = countInc;
            if (countInc == total) // RULE_08 RULE_09 RULE_10
            begin
                next_s.nibbleCycleCounter = 3'h0;
                case (s.addr)
                    ADDR_INTR: ackSet = s.hold[STATUS_POS +: 4]; // RULE_05
                    ADDR_SIGNAL: done[BIT_FREQ] = 1'b1; // RULE_15
                    ADDR_POS_PEAK, ADDR_NEG_PEAK: done[BIT_PEAK] = 1'b1; // RULE_16
                    ADDR_COARSE: done[BIT_COARSE] = 1'b1;
                    ADDR_FINE: done[BIT_FINE] = 1'b1;
                    default: done = 4'h0;
                endcase
            end
        end

        // Writes: MSB nibble first, only the enable nibble stores
        if (wrRise)
        begin
            next_s.nibbleCycleCounter = (s.nibbleCycleCounter == 3'h0) ? 3'h1 : 3'h0;
            if (s.nibbleCycleCounter != 3'h0 && s.addr == ADDR_INTR)
            begin
                next_s.enable = s.adS[7:4]; // RULE_07 RULE_11
            end
        end

        // Clear acts on the strobe's falling edge
        next_s.statusClearStrobe = done;
        next_s.strobePrev = s.statusClearStrobe;
        clearFall = s.strobePrev & ~s.statusClearStrobe; // RULE_12
        // Set beats clear; enables play no part here
        next_s.status = (s.status & ~clearFall) | newVals; // RULE_04
        // A fresh event re-arms a bit acknowledged earlier
        next_s.acked = (s.acked | ackSet) & ~newVals;
        // NOR of masked, unacknowledged status
        next_s.irqOutN = ~|(next_s.status & next_s.enable & ~next_s.acked); // RULE_01 RULE_03 RULE_19
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.csS <= 2'b11;
            s.rdS <= 2'b11;
            s.wrS <= 2'b11;
            s.rdPrev <= 1'b1;
            s.wrPrev <= 1'b1;
            s.status <= STATUS_RESET;
            s.enable <= ENABLE_RESET; // RULE_18
            s.adDriveN <= 1'b1;
            s.irqOutN <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign bus.devAd = s.adOut;
    assign bus.devAdDriveN = s.adDriveN;
    assign bus.irqOutN = s.irqOutN;
    assign eventStatus = s.status;
    assign eventEnable = s.enable;

endmodule

/* design/mir_host.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Microprocessor end: runs one register access per command
// ----------------------------------------------------------------
module mir_host
    import mir_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_PERIOD_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmdStart,
    input wire logic cmdWrite,
    input wire logic [3:0] cmdAddr,
    input wire logic [7:0] cmdData,
    output logic cmdBusy,
    output logic cmdDone,
    output logic [23:0] readData,
    output logic irqSeen,
    mir_bus_if.host bus
);

    // Timer holds 12 bits; strobe must outlast the short minimum
    if (SAMPLE_CYC < STROBE_MIN_CYC || SAMPLE_CYC > 4094)
    begin : g_check
        $error("SAMPLE_CYC out of range");
    end

    typedef enum logic [2:0] {IDLE, ADDR, SETTLE, STROBE, GAP, FINISH} mir_phase_t;

    typedef struct packed {
        mir_phase_t phase;
        logic [11:0] timer;
        logic [3:0] addr;
        logic isWrite;
        logic [7:0] wdata;
        logic [2:0] idx;
        logic [23:0] shiftReg;
        logic [1:0] irqS;
        logic [7:0] adS;
        logic csN;
        logic ale;
        logic rdN;
        logic wrN;
        logic [3:0] adOut;
        logic adDriveN;
        logic busy;
        logic done;
        logic [23:0] rdata;
    } mir_host_state_t;

    mir_host_state_t s;
    mir_host_state_t next_s;
    logic [2:0] total;
    logic isAdc;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        // Device pins pass two flops
        next_s.irqS = {s.irqS[0], bus.irqOutN};
        next_s.adS = {s.adS[3:0], bus.ad};
        total = s.isWrite ? NIB_BYTE : mirNibbleCount(s.addr);
        isAdc = (s.addr == ADDR_COARSE) || (s.addr == ADDR_FINE);
        if (s.timer != 12'h000)
        begin
            next_s.timer = s.timer - 12'h001;
        end
        case (s.phase)
            IDLE:
            begin
                if (cmdStart)
                begin
                    next_s.phase = ADDR;
                    next_s.addr = cmdAddr;
                    next_s.isWrite = cmdWrite;
                    next_s.wdata = cmdData;
                    next_s.idx = 3'h0;
                    next_s.shiftReg = 24'h000000;
                    next_s.busy = 1'b1;
                    next_s.csN = 1'b0;
                    next_s.ale = 1'b1; // RULE_17
                    next_s.adOut = cmdAddr;
                    next_s.adDriveN = 1'b0;
                    next_s.timer = 12'(PHASE_CYC);
                end
            end
            ADDR:
            begin
                if (s.timer == 12'h000)
                begin
                    next_s.phase = SETTLE;
                    next_s.ale = 1'b0;
                    next_s.timer = 12'(PHASE_CYC);
                end
            end
            SETTLE, GAP:
            begin
                if (s.timer == 12'h000)
                begin
                    if (s.phase == GAP && s.idx == total)
                    begin
                        next_s.phase = FINISH;
                        next_s.csN = 1'b1;
                        next_s.adDriveN = 1'b1;
                    end
                    else
                    begin
                        next_s.phase = STROBE;
                        // First ADC nibble waits out a sample period
                        next_s.timer = (!s.isWrite && isAdc && s.idx == 3'h0) ?
                            12'(SAMPLE_CYC + 1) : 12'(STROBE_MIN_CYC + 1); // RULE_14
                        if (s.isWrite)
                        begin
                            next_s.wrN = 1'b0;
                            next_s.adOut = (s.idx == 3'h0) ? s.wdata[7:4] : s.wdata[3:0];
                        end
                        else
                        begin
                            next_s.rdN = 1'b0;
                            next_s.adDriveN = 1'b1;
                        end
                    end
                end
            end
            STROBE:
            begin
                if (s.timer == 12'h000)
                begin
                    next_s.phase = GAP;
                    next_s.rdN = 1'b1;
                    next_s.wrN = 1'b1;
                    next_s.idx = s.idx + 3'h1; // RULE_13
                    next_s.timer = 12'(PHASE_CYC);
                    if (!s.isWrite)
                    begin
                        next_s.shiftReg = {s.shiftReg[19:0], s.adS[7:4]};
                    end
                end
            end
            FINISH:
            begin
                next_s.phase = IDLE;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.rdata = s.shiftReg;
            end
            default: next_s.phase = IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.phase <= IDLE;
            s.irqS <= 2'b11;
            s.csN <= 1'b1;
            s.rdN <= 1'b1;
            s.wrN <= 1'b1;
            s.adDriveN <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.csN = s.csN;
    assign bus.ale = s.ale;
    assign bus.rdN = s.rdN;
    assign bus.wrN = s.wrN;
    assign bus.hostAd = s.adOut;
    assign bus.hostAdDriveN = s.adDriveN;
    assign cmdBusy = s.busy;
    assign cmdDone = s.done;
    assign readData = s.rdata;
    // Interrupt line still low after a status read tells user to reread
    assign irqSeen = ~s.irqS[1]; // RULE_06

endmodule

/* verif/mir_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus checker beside the host/meter interface
// ----------------------------------------------------------------
module mir_chk
    import mir_pkg::*;
(
    input logic clk,
    input logic rstn,
    input logic csN,
    input logic ale,
    input logic rdN,
    input logic wrN,
    input logic [3:0] hostAd,
    input logic hostAdDriveN,
    input logic [3:0] devAd,
    input logic devAdDriveN,
    input logic irqOutN,
    input logic [3:0] ad
);
    int lowCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Length of the current read strobe, in cycles
    always_ff @(posedge clk)
    begin
        if (!rstn || rdN)
            lowCnt <= 0;
        else
            lowCnt <= lowCnt + 1;
    end

    // Steps of one nibble transfer
    sequence sAddrHold;
        ale [*8];
    endsequence
    sequence sAnswer;
        ##[2:5] !devAdDriveN;
    endsequence
    sequence sRelease;
        ##[2:5] devAdDriveN;
    endsequence

    AST_ADDR_PHASE: assert property ($rose(ale) |-> sAddrHold)
        else $error("address phase shorter than eight cycles");
    AST_ADDR_DRIVEN: assert property (ale |-> !hostAdDriveN && ad == hostAd && rdN && wrN)
        else $error("address phase without host drive or with a strobe");
    AST_READ_ANSWER: assert property ($fell(rdN) && !csN |-> sAnswer)
        else $error("device did not answer a read strobe in time");
    AST_READ_RELEASE: assert property ($rose(rdN) |-> sRelease)
        else $error("device kept the nibble bus after the read strobe");
    AST_DRIVE_CAUSE: assert property ($fell(devAdDriveN) |-> $past(rdN, 3) == 1'b0)
        else $error("device drove the nibble bus without a read strobe");
    AST_NO_CONTENTION: assert property (!(!devAdDriveN && !hostAdDriveN))
        else $error("both ends drive the nibble bus");
    AST_WRITE_QUIET: assert property (!wrN |-> devAdDriveN)
        else $error("device drove the bus during a write");
    AST_IRQ_RELEASE: assert property ($rose(irqOutN) |-> !csN)
        else $error("interrupt released outside an access");
    AST_STROBE_WIDTH: assert property ($rose(rdN) |-> lowCnt >= STROBE_MIN_CYC)
        else $error("read strobe shorter than the minimum");
    // Device nibble must reach the wire while it drives
    AST_DEV_NIBBLE: assert property (!devAdDriveN |-> ad == devAd)
        else $error("device nibble not seen on the bus");
endmodule

/* verif/tb_meas_irq_readout.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host end against meter end, driven through the command port
// ----------------------------------------------------------------
module tb_meas_irq_readout;
    // Status expected after each measurement read, 0xA first
    localparam logic [23:0] STATUS_AFTER = 24'hF73310;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmdStart, cmdWrite, cmdBusy, cmdDone, irqSeen;
    logic [3:0] cmdAddr, valids, eventStatus, eventEnable;
    logic [7:0] cmdData;
    logic [23:0] readData, timebaseCount, signalCount, fineAdcResult, expV;
    logic [15:0] positivePeak, negativePeak, coarseAdcResult;
    int n_errors = 0;
    int samples_checked = 0;

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    mir_bus_if busIf ();
    mir_device i_mir_device (.clk(clk), .rstn(rstn), .timebaseCount(timebaseCount),
        .signalCount(signalCount), .freqValid(valids[3]), .positivePeak(positivePeak),
        .negativePeak(negativePeak), .peakValid(valids[2]), .coarseAdcResult(coarseAdcResult),
        .coarseValid(valids[1]), .fineAdcResult(fineAdcResult), .fineValid(valids[0]),
        .eventStatus(eventStatus), .eventEnable(eventEnable), .bus(busIf));
    // Short sample period keeps ADC reads brief
    mir_host #(.SAMPLE_CYC(250)) i_mir_host (.clk(clk), .rstn(rstn), .cmdStart(cmdStart),
        .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdBusy(cmdBusy),
        .cmdDone(cmdDone), .readData(readData), .irqSeen(irqSeen), .bus(busIf));
    mir_chk i_mir_chk (.clk(clk), .rstn(rstn), .csN(busIf.csN), .ale(busIf.ale),
        .rdN(busIf.rdN), .wrN(busIf.wrN), .hostAd(busIf.hostAd),
        .hostAdDriveN(busIf.hostAdDriveN), .devAd(busIf.devAd),
        .devAdDriveN(busIf.devAdDriveN), .irqOutN(busIf.irqOutN), .ad(busIf.ad));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // One register access; idle cycle first so busy has dropped
    task automatic access(input logic wr, input logic [3:0] addr, input logic [7:0] data);
        int i;
        @(negedge clk);
        cmdStart = 1'b1;
        cmdWrite = wr;
        cmdAddr = addr;
        cmdData = data;
        @(negedge clk);
        cmdStart = 1'b0;
        chk("busy", 24'h1, cmdBusy);
        for (i = 0; i < 4000 && cmdDone !== 1'b1; i++)
            @(negedge clk);
        if (i == 4000)
        begin
            n_errors++;
            give_verdict();
        end
        chk("busy", 24'h0, cmdBusy);
    endtask

    task automatic rd(input logic [3:0] addr, input logic [23:0] exp, input string what);
        access(1'b0, addr, 8'h00);
        chk(what, exp, readData);
    endtask

    // New-value pulse of one source, then let status and irq settle
    task automatic pulse(input int src);
        @(negedge clk);
        valids = 4'h1 << src;
        @(negedge clk);
        valids = 4'h0;
        repeat (4) @(negedge clk);
    endtask

    function automatic logic [23:0] measVal(input int a);
        case (a)
            10: return timebaseCount;
            11: return signalCount;
            12: return {8'h00, positivePeak};
            13: return {8'h00, negativePeak};
            14: return {8'h00, coarseAdcResult};
            default: return fineAdcResult;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cmdStart = 1'b0;
        cmdWrite = 1'b0;
        cmdAddr = 4'h0;
        cmdData = 8'h00;
        valids = 4'h0;
        timebaseCount = 24'h123456;
        signalCount = 24'hABCDEF;
        positivePeak = 16'h7FA1;
        negativePeak = 16'h805E;
        coarseAdcResult = 16'h3C5A;
        fineAdcResult = 24'h9E0D17;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk("enable", 24'h0, eventEnable);
        rd(mir_pkg::ADDR_INTR, 24'h00, "intr reset");
        access(1'b1, mir_pkg::ADDR_INTR, 8'hA5);
        rd(mir_pkg::ADDR_INTR, 24'h05, "intr write");
        chk("enable", 24'h5, eventEnable);
        // Sources one by one, each lands on its own status bit
        for (int s = 0; s < 4; s++)
        begin
            pulse(s);
            chk("status", (24'h2 << s) - 24'h1, eventStatus);
        end
        chk("irq", 24'h0, busIf.irqOutN);
        chk("irq seen", 24'h1, irqSeen);
        rd(mir_pkg::ADDR_INTR, 24'hF5, "intr events");
        repeat (8) @(negedge clk);
        chk("irq", 24'h1, busIf.irqOutN);
        chk("irq seen", 24'h0, irqSeen);
        chk("status", 24'hF, eventStatus);
        // Every measurement register; peak re-armed before the second peak read
        for (int a = 10; a < 16; a++)
        begin
            if (a == 13)
                pulse(2);
            rd(4'(a), measVal(a), "measure");
            repeat (4) @(negedge clk);
            chk("status", STATUS_AFTER[4 * (15 - a) +: 4], eventStatus);
        end
        // Masked source still sets status but not the line
        access(1'b1, mir_pkg::ADDR_INTR, 8'h00);
        pulse(1);
        chk("status", 24'h2, eventStatus);
        chk("irq", 24'h1, busIf.irqOutN);
        access(1'b1, mir_pkg::ADDR_INTR, 8'h02);
        chk("irq", 24'h0, busIf.irqOutN);
        // Write is ignored; update during readout must not tear the value
        access(1'b1, mir_pkg::ADDR_FINE, 8'h55);
        expV = fineAdcResult;
        fork
            rd(mir_pkg::ADDR_FINE, expV, "held value");
            begin
                repeat (300) @(negedge clk);
                fineAdcResult = 24'h000001;
                pulse(0);
            end
        join
        rd(mir_pkg::ADDR_FINE, 24'h000001, "new value");
        give_verdict();
    end
endmodule
